//--- hw/tws_pkg.sv
// Purpose: shared constants and types of the two-wire slave state engine
// Assumes: 32-bit AHB-Lite register window, 8-bit registers in low lanes
// Notes:   status codes are stored with the two low bits zero

package tws_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] RST_DATA = 8'hff;
   localparam logic [7:0] RST_STATUS = 8'hf8;

   // ----------------------------------------------------------------
   // control register bit positions, own-address general call enable bit
   // ----------------------------------------------------------------
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK_EN = 6;
   localparam int CTL_START_REQ = 5;
   localparam int CTL_STOP_REQ = 4;
   localparam int CTL_WCOL = 3;
   localparam int CTL_ENABLE = 2;
   localparam int CTL_IRQ_EN = 0;
   localparam int OWN_GC_EN = 0;

   // ----------------------------------------------------------------
   // status codes, prescaler bits taken as zero; general call address byte
   // ----------------------------------------------------------------
   localparam logic [7:0] SC_RX_ADDR = 8'h60;
   localparam logic [7:0] SC_RX_ARB = 8'h68;
   localparam logic [7:0] SC_GC_ADDR = 8'h70;
   localparam logic [7:0] SC_GC_ARB = 8'h78;
   localparam logic [7:0] SC_RX_ACK = 8'h80;
   localparam logic [7:0] SC_RX_NACK = 8'h88;
   localparam logic [7:0] SC_GC_ACK = 8'h90;
   localparam logic [7:0] SC_GC_NACK = 8'h98;
   localparam logic [7:0] SC_STOP_RESTART = 8'ha0;
   localparam logic [7:0] SC_TX_ADDR = 8'ha8;
   localparam logic [7:0] SC_TX_ARB = 8'hb0;
   localparam logic [7:0] SC_TX_ACK = 8'hb8;
   localparam logic [7:0] SC_TX_NACK = 8'hc0;
   localparam logic [7:0] SC_TX_LAST_ACK = 8'hc8;
   localparam logic [7:0] SC_NO_INFO = 8'hf8;
   localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // bit counting
   // ----------------------------------------------------------------
   localparam logic [3:0] CNT_BYTE_BITS = 4'h8;
   localparam logic [3:0] CNT_LAST_TX_BIT = 4'h7;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // synchronised line events from the monitor
   typedef struct packed {
      logic sclRise;
      logic sclFall;
      logic sdaLvl;
      logic start;
      logic stop;
      logic busBusy;
   } tws_line_t;

   // software-owned control bits
   typedef struct packed {
      logic ackEn;
      logic startReq;
      logic stopReq;
      logic enable;
      logic irqEn;
   } tws_ctl_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_RX_BYTE,
      ST_RX_ACK,
      ST_TX_BYTE,
      ST_TX_ACK,
      ST_HOLD
   } tws_state_t;

endpackage : tws_pkg

//--- hw/tws_line_monitor.sv
// Purpose: synchronise the serial clock and data pins, find edges and conditions
// Assumes: pins idle high; clk much faster than the serial clock
// Notes:   outputs are registered and one cycle behind the second sync stage

`timescale 1ns/10ps
`default_nettype none

module tws_line_monitor
   import tws_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // raw pins
   input wire logic sclPin,
   input wire logic sdaPin,
   // events
   output tws_line_t line
);

   logic sclMeta, sclSync, sclLast;
   logic sdaMeta, sdaSync, sdaLast;

   // ----------------------------------------------------------------
   // two-stage synchronisers plus history stage
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sclMeta <= 1'b1;
         sclSync <= 1'b1;
         sclLast <= 1'b1;
         sdaMeta <= 1'b1;
         sdaSync <= 1'b1;
         sdaLast <= 1'b1;
      end else begin
         sclMeta <= sclPin;
         sclSync <= sclMeta;
         sclLast <= sclSync;
         sdaMeta <= sdaPin;
         sdaSync <= sdaMeta;
         sdaLast <= sdaSync;
      end
   end

   // edges, start and stop, bus occupancy
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         line <= '{sclRise: 1'b0, sclFall: 1'b0, sdaLvl: 1'b1, start: 1'b0,
                   stop: 1'b0, busBusy: 1'b0};
      end else begin
         line.sclRise <= sclSync & ~sclLast;
         line.sclFall <= ~sclSync & sclLast;
         line.sdaLvl <= sdaSync;
         line.start <= sclSync & sclLast & sdaLast & ~sdaSync;
         line.stop <= sclSync & sclLast & ~sdaLast & sdaSync;
         if (sclSync && sclLast && sdaLast && !sdaSync) begin
            line.busBusy <= 1'b1;
         end else if (sclSync && sclLast && !sdaLast && sdaSync) begin
            line.busBusy <= 1'b0;
         end
      end
   end

endmodule : tws_line_monitor

`default_nettype wire

//--- hw/tws_slave.sv
// Purpose: slave receive/transmit state engine of a two-wire serial interface
// Assumes: AHB-Lite register access, pins sampled on clk, open-drain pads
// Notes:   master modes are outside; arbitration loss arrives as an input
//
// Behaviour
// - status read with prescaler bits zero
// - upper seven own-address bits are slave address
// - own-address bit 0 enables general call
// - read bit enters transmit, write enters receive
// - address match sets flag with valid status
// - lost arbitration then read reports 0xB0
// - ack-enable cleared makes current byte final
// - final byte gives 0xC0 on NACK, 0xC8 on ACK
// - after final byte ignore master, ones read
// - ack-enable zero: own address not answered
// - ack-enable zero still monitors, resumes when set
// - status 0x90 clear receives next, ack per enable
// - status 0x98 clear goes not addressed
// - stop or restart while addressed as receiver reports 0xA0
// - not addressed, ack-enable zero: recognise nothing
// - not addressed, ack-enable one: own, general call
// - pending start request issued when bus frees
// - flag cleared by writing one; continues
// - own address read acknowledged reports 0xA8
// - transmitted byte acknowledged reports 0xB8

`timescale 1ns/10ps
`default_nettype none

module tws_slave
   import tws_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // serial clock pad
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   // serial data pad
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // master-side coupling
   input wire logic arbitrationLost,
   output logic startIssue,
   output logic busBusy
);

   tws_line_t line;
   tws_ctl_t ctl;
   tws_state_t state, resumeState;
   logic [7:0] ownAddr, dataReg, shiftReg, statusCode, readByte;
   logic [3:0] bitCnt;
   logic byteFlag, wcol, isGenCall, viaArbLost, lastByte, ackGiven, startPending;
   logic sdaLow;
   logic dpValid, dpWrite, rdDone, rdStall, wrEn;
   logic [7:0] dpAddr;
   logic flagClr, dataWr, ownMatch, gcMatch;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true while addressed as receiver (own or general call)
   function automatic logic inRxTransfer(input tws_state_t s, input tws_state_t r);
      inRxTransfer = (s == ST_RX_BYTE) || (s == ST_RX_ACK) ||
                     ((s == ST_HOLD) && (r == ST_RX_BYTE));
   endfunction : inRxTransfer

   // choose plain or arbitration-lost code
   function automatic logic [7:0] pickCode(input logic arb, input logic [7:0] plain,
                                           input logic [7:0] lost);
      pickCode = arb ? lost : plain;
   endfunction : pickCode

   // ----------------------------------------------------------------
   // line monitor
   // ----------------------------------------------------------------
   tws_line_monitor i_tws_line_monitor (
      .clk(clk),
      .rst_b(rst_b),
      .sclPin(sclIn),
      .sdaPin(sdaIn),
      .line(line)
   );

   assign busBusy = line.busBusy;

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   // address phase capture
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dpValid <= 1'b0;
         dpWrite <= 1'b0;
         dpAddr <= 8'h00;
      end else if (hready) begin
         dpValid <= hsel & htrans[1];
         dpWrite <= hwrite;
         dpAddr <= haddr[7:0];
      end
   end

   // reads take one wait state so that the data come from a flop
   assign rdStall = dpValid & ~dpWrite & ~rdDone;
   assign hreadyout = ~rdStall;
   assign hresp = 1'b0;
   assign wrEn = dpValid & dpWrite;
   assign flagClr = wrEn && (dpAddr == OFS_CONTROL) && hwdata[CTL_FLAG];
   assign dataWr = wrEn && (dpAddr == OFS_DATA);

   // read data register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdDone <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         rdDone <= rdStall;
         if (rdStall) begin
            hrdata <= {24'h00_0000, readByte};
         end
      end
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      unique case (dpAddr)
         OFS_OWN_ADDR: readByte = ownAddr;
         OFS_CONTROL: readByte = {byteFlag, ctl.ackEn, ctl.startReq, ctl.stopReq, wcol,
                                  ctl.enable, 1'b0, ctl.irqEn};
         OFS_STATUS: readByte = byteFlag ? {statusCode[7:2], 2'b00} : SC_NO_INFO;
         OFS_DATA: readByte = dataReg;
         default: readByte = 8'h00;
      endcase
   end

   // software-owned registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ownAddr <= RST_OWN_ADDR;
         ctl <= '0;
      end else if (wrEn) begin
         if (dpAddr == OFS_OWN_ADDR) begin
            ownAddr <= hwdata[7:0];
         end
         if (dpAddr == OFS_CONTROL) begin
            ctl.ackEn <= hwdata[CTL_ACK_EN];
            ctl.startReq <= hwdata[CTL_START_REQ];
            ctl.stopReq <= hwdata[CTL_STOP_REQ];
            ctl.enable <= hwdata[CTL_ENABLE];
            ctl.irqEn <= hwdata[CTL_IRQ_EN];
         end
      end
   end

   // ----------------------------------------------------------------
   // address recognition
   // ----------------------------------------------------------------
   // live acknowledge enable gates both matches
   assign ownMatch = ctl.ackEn && (shiftReg[7:1] == ownAddr[7:1]);
   assign gcMatch = ctl.ackEn && ownAddr[OWN_GC_EN] &&
                    (shiftReg == GENERAL_CALL_BYTE);

   // ----------------------------------------------------------------
   // slave state engine
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         resumeState <= ST_IDLE;
         bitCnt <= 4'h0;
         shiftReg <= 8'h00;
         sdaLow <= 1'b0;
         byteFlag <= 1'b0;
         statusCode <= RST_STATUS;
         dataReg <= RST_DATA;
         wcol <= 1'b0;
         isGenCall <= 1'b0;
         viaArbLost <= 1'b0;
         lastByte <= 1'b0;
         ackGiven <= 1'b0;
         startPending <= 1'b0;
         startIssue <= 1'b0;
      end else begin
         startIssue <= 1'b0;
         // clear first; any set below in this cycle wins
         if (flagClr) begin
            byteFlag <= 1'b0;
         end
         // data writes only count while the flag is set
         if (dataWr) begin
            if (byteFlag) begin
               dataReg <= hwdata[7:0];
               wcol <= 1'b0;
            end else begin
               wcol <= 1'b1;
            end
         end
         // queued start goes out once the bus is free
         if (startPending && !line.busBusy) begin
            startIssue <= 1'b1;
            startPending <= 1'b0;
         end
         if (!ctl.enable) begin
            state <= ST_IDLE;
            sdaLow <= 1'b0;
         end else if (line.stop) begin
            if (inRxTransfer(state, resumeState)) begin
               byteFlag <= 1'b1;
               statusCode <= SC_STOP_RESTART;
               resumeState <= ST_IDLE;
               state <= ST_HOLD;
            end else begin
               state <= ST_IDLE;
            end
            sdaLow <= 1'b0;
         end else if (line.start) begin
            if (inRxTransfer(state, resumeState)) begin
               byteFlag <= 1'b1;
               statusCode <= SC_STOP_RESTART;
            end
            state <= ST_ADDR;
            bitCnt <= 4'h0;
            viaArbLost <= 1'b0;
            sdaLow <= 1'b0;
         end else begin
            unique case (state)
               ST_IDLE: begin
                  sdaLow <= 1'b0; // not addressed: master reads ones
               end
               ST_ADDR: begin
                  if (arbitrationLost) begin
                     viaArbLost <= 1'b1;
                  end
                  if (line.sclRise) begin
                     shiftReg <= {shiftReg[6:0], line.sdaLvl};
                     bitCnt <= bitCnt + 4'h1;
                  end else if (line.sclFall && (bitCnt == CNT_BYTE_BITS)) begin
                     if (ownMatch || gcMatch) begin
                        sdaLow <= 1'b1;
                        isGenCall <= ~ownMatch;
                        state <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (line.sclFall) begin
                     sdaLow <= 1'b0;
                     byteFlag <= 1'b1;
                     state <= ST_HOLD;
                     if (isGenCall) begin
                        statusCode <= pickCode(viaArbLost, SC_GC_ADDR, SC_GC_ARB);
                        resumeState <= ST_RX_BYTE;
                     end else if (shiftReg[0]) begin
                        statusCode <= pickCode(viaArbLost, SC_TX_ADDR, SC_TX_ARB);
                        resumeState <= ST_TX_BYTE;
                     end else begin
                        statusCode <= pickCode(viaArbLost, SC_RX_ADDR, SC_RX_ARB);
                        resumeState <= ST_RX_BYTE;
                     end
                  end
               end
               ST_HOLD: begin
                  if (!byteFlag) begin
                     bitCnt <= 4'h0;
                     state <= resumeState;
                     if (resumeState == ST_TX_BYTE) begin
                        shiftReg <= dataReg;
                        sdaLow <= ~dataReg[7];
                        lastByte <= ~ctl.ackEn;
                     end
                     if ((resumeState == ST_IDLE) && ctl.startReq) begin
                        startPending <= 1'b1;
                     end
                  end
               end
               ST_RX_BYTE: begin
                  if (line.sclRise) begin
                     shiftReg <= {shiftReg[6:0], line.sdaLvl};
                     bitCnt <= bitCnt + 4'h1;
                  end else if (line.sclFall && (bitCnt == CNT_BYTE_BITS)) begin
                     dataReg <= shiftReg;
                     ackGiven <= ctl.ackEn;
                     sdaLow <= ctl.ackEn;
                     state <= ST_RX_ACK;
                  end
               end
               ST_RX_ACK: begin
                  if (line.sclFall) begin
                     sdaLow <= 1'b0;
                     byteFlag <= 1'b1;
                     state <= ST_HOLD;
                     resumeState <= ackGiven ? ST_RX_BYTE : ST_IDLE;
                     if (isGenCall) begin
                        statusCode <= ackGiven ? SC_GC_ACK : SC_GC_NACK;
                     end else begin
                        statusCode <= ackGiven ? SC_RX_ACK : SC_RX_NACK;
                     end
                  end
               end
               ST_TX_BYTE: begin
                  if (line.sclFall) begin
                     if (bitCnt == CNT_LAST_TX_BIT) begin
                        sdaLow <= 1'b0;
                        state <= ST_TX_ACK;
                     end else begin
                        bitCnt <= bitCnt + 4'h1;
                        shiftReg <= {shiftReg[6:0], 1'b1};
                        sdaLow <= ~shiftReg[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (line.sclRise) begin
                     ackGiven <= ~line.sdaLvl;
                  end else if (line.sclFall) begin
                     byteFlag <= 1'b1;
                     state <= ST_HOLD;
                     if (lastByte) begin
                        statusCode <= ackGiven ? SC_TX_LAST_ACK : SC_TX_NACK;
                        resumeState <= ST_IDLE;
                     end else if (ackGiven) begin
                        statusCode <= SC_TX_ACK;
                        resumeState <= ST_TX_BYTE;
                     end else begin
                        statusCode <= SC_TX_NACK;
                        resumeState <= ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // pad drivers, open drain: only ever pull low
   // ----------------------------------------------------------------
   // clock stretch while software services an addressed transfer;
   // ends with the first transmit bit, never ahead of it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sclOe <= 1'b0;
         sdaOe <= 1'b0;
      end else begin
         sclOe <= (state == ST_HOLD) && (resumeState != ST_IDLE);
         sdaOe <= sdaLow;
      end
   end

   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;

endmodule : tws_slave

`default_nettype wire

//--- sim/tws_slave_props.sv
// Purpose: port-level properties of the two-wire slave engine
// Assumes: hready tied to hreadyout, one clock domain
// Notes: bound into every instance of the slave
`timescale 1ns/10ps
`default_nettype none
module tws_slave_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // serial pads and coupling
   input wire logic sclIn,
   input wire logic sclOe,
   input wire logic sdaIn,
   input wire logic sdaOe,
   input wire logic startIssue,
   input wire logic busBusy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // register bus timing and lanes
   read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
      |=> !hreadyout ##1 hreadyout) else $error("read data phase not one wait state");
   write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   data_lane_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
      else $error("read data above low lane not zero");
   // pad drive only inside a frame
   stretch_busy_a: assert property (sclOe |-> busBusy)
      else $error("clock held low outside a frame");
   drive_busy_a: assert property (sdaOe |-> busBusy)
      else $error("data line driven outside a frame");
   // start issue is a pulse on a free bus
   issue_pulse_a: assert property (startIssue |=> !startIssue)
      else $error("start issue longer than one cycle");
   issue_free_a: assert property (startIssue |-> !busBusy)
      else $error("start issue while bus busy");
   // bus stays monitored: a start always marks the bus busy
   start_seen_a: assert property (sclIn && $past(sclIn) && $fell(sdaIn) |-> ##[1:8] busBusy)
      else $error("start condition not seen");
endmodule : tws_slave_props
bind tws_slave tws_slave_props i_tws_slave_props (.*);
`default_nettype wire

//--- sim/tws_i2c_master.sv
// Purpose: behavioural master on the slave's serial pins
// Assumes: bench resolves open-drain wires with pull-ups
// Notes: waits on the clock wire, so stretching is honoured
`timescale 1ns/10ps
`default_nettype none
module tws_i2c_master #(
   parameter int HALF = 24
) (
   // pulls, high drives the wire low
   output logic sclPull,
   output logic sdaPull,
   // resolved wire levels
   input wire logic sclW,
   input wire logic sdaW
);
   initial begin
      sclPull = 1'h0;
      sdaPull = 1'h0;
   end
   // one bit: data set while low, sampled midway through the high phase;
   // long low phase covers the slave's synchroniser latency
   task automatic bit_io(input logic b, output logic r);
      sdaPull = !b;
      #(HALF + HALF / 3);
      sclPull = 1'h0;
      wait (sclW);
      #(HALF / 3);
      r = sdaW;
      #(HALF / 3);
      sclPull = 1'h1;
   endtask : bit_io
   // start: data falls while clock high
   task automatic start;
      sdaPull = 1'h0;
      sclPull = 1'h0;
      #HALF;
      sdaPull = 1'h1;
      #HALF;
      sclPull = 1'h1;
   endtask : start
   // stop: data rises while clock high, then bus idle
   task automatic stop;
      sdaPull = 1'h1;
      #HALF;
      sclPull = 1'h0;
      wait (sclW);
      #HALF;
      sdaPull = 1'h0;
      #HALF;
   endtask : stop
   // byte out msb first, ack bit back; slow master after the ack
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(b[i], ack);
      bit_io(1'h1, ack);
      #(2 * HALF);
   endtask : wbyte
   // byte in msb first, ack bit sent back
   task automatic rbyte(input logic ak, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, r);
         b[i] = r;
      end
      bit_io(ak, r);
      #(2 * HALF);
   endtask : rbyte
endmodule : tws_i2c_master
`default_nettype wire

//--- sim/tws_slave_tb.sv
// Purpose: self-checking bench of the two-wire slave engine
// Assumes: behavioural master on the pins, AHB-Lite tasks
// Notes: drivers queue expectations, checks pop them in order
`timescale 1ns/10ps
`default_nettype none
module tws_slave_tb
   import tws_pkg::*;
;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic hsel = 1'h0, hwrite = 1'h0, arbLost = 1'h0, rdPh = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed;
   logic hreadyout, sclOe, sdaOe, startIssue, busBusy, mScl, mSda;
   logic [7:0] d1, d2, v, eq[$];
   string nq[$];
   int nMismatch = 0;
   int cmpCount = 0;
   wire logic sclW = !(mScl || sclOe);
   wire logic sdaW = !(mSda || sdaOe);
   tws_slave i_tws_slave (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .sclIn(sclW), .sclOut(), .sclOe,
      .sdaIn(sdaW), .sdaOut(), .sdaOe, .arbitrationLost(arbLost), .startIssue, .busBusy);
   tws_i2c_master i_tws_i2c_master (.sclPull(mScl), .sdaPull(mSda), .sclW, .sdaW);
   // 200 MHz clock
   always #2.5 clk = !clk;
   // monitor: read data taken where hreadyout ends the data phase
   always @(negedge clk) if (rdPh && hreadyout === 1'h1) got(hrdata[7:0]);
   // watchdog well beyond the expected run of some 8 us
   initial begin
      #400000;
      nMismatch++;
      test_done;
   end
   task automatic note(input string n, input logic [7:0] e);
      nq.push_back(n);
      eq.push_back(e);
   endtask : note
   task automatic got(input logic [7:0] s);
      string n;
      logic [7:0] e;
      n = nq.pop_front();
      e = eq.pop_front();
      cmpCount++;
      if (s !== e) begin
         nMismatch++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : got
   // wait for an edge with hready high
   task automatic wt;
      do @(negedge clk); while (hreadyout !== 1'h1);
      @(posedge clk);
   endtask : wt
   task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wt;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdPh <= !w;
      wt;
      rdPh <= 1'h0;
   endtask : ahb
   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      note(n, e);
      ahb(1'h0, a, 8'h0);
   endtask : rd
   // master byte: write when wr, else read with ack bit ak
   task automatic xf(input logic wr, input logic [7:0] b, input logic ak, input logic [7:0] e);
      logic [7:0] r;
      r = 8'h0;
      if (wr) i_tws_i2c_master.wbyte(b, r[0]);
      else i_tws_i2c_master.rbyte(ak, r);
      note(wr ? "ack" : "byte", e);
      got(r);
   endtask : xf
   // xorshift step for the random fields
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      xorshift = s ^ (s << 5);
   endfunction : xorshift
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial begin
      seed = xorshift(32'h614e);
      d1 = seed[15:8];
      d2 = seed[23:16];
      v = {seed[6:0] | 7'h01, 1'h0};
      repeat (10) @(posedge clk);
      rst_b <= 1'h1;
      rd("own", OFS_OWN_ADDR, RST_OWN_ADDR);
      rd("data", OFS_DATA, RST_DATA);
      rd("status", OFS_STATUS, RST_STATUS);
      rd("unmapped", 8'h10, 8'h0);
      ahb(1'h1, OFS_OWN_ADDR, v | 8'h01);
      ahb(1'h1, OFS_CONTROL, 8'h44);
      $display("test 1 done");
      i_tws_i2c_master.start;
      xf(1'h1, v | 8'h01, 1'h0, 8'h0);
      rd("status", OFS_STATUS, SC_TX_ADDR);
      ahb(1'h1, OFS_DATA, d1);
      ahb(1'h1, OFS_CONTROL, 8'hc4);
      xf(1'h0, 8'h0, 1'h0, d1);
      rd("status", OFS_STATUS, SC_TX_ACK);
      ahb(1'h1, OFS_DATA, d2);
      ahb(1'h1, OFS_CONTROL, 8'h84);
      xf(1'h0, 8'h0, 1'h0, d2);
      rd("status", OFS_STATUS, SC_TX_LAST_ACK);
      ahb(1'h1, OFS_CONTROL, 8'h84);
      xf(1'h0, 8'h0, 1'h1, 8'hff);
      i_tws_i2c_master.stop;
      $display("test 2 done");
      i_tws_i2c_master.start;
      xf(1'h1, v, 1'h0, 8'h1);
      i_tws_i2c_master.stop;
      rd("status", OFS_STATUS, SC_NO_INFO);
      $display("test 3 done");
      ahb(1'h1, OFS_CONTROL, 8'h44);
      i_tws_i2c_master.start;
      xf(1'h1, GENERAL_CALL_BYTE, 1'h0, 8'h0);
      rd("status", OFS_STATUS, SC_GC_ADDR);
      ahb(1'h1, OFS_CONTROL, 8'hc4);
      xf(1'h1, d1, 1'h0, 8'h0);
      rd("status", OFS_STATUS, SC_GC_ACK);
      rd("data", OFS_DATA, d1);
      ahb(1'h1, OFS_CONTROL, 8'h84);
      xf(1'h1, d2, 1'h0, 8'h1);
      rd("status", OFS_STATUS, SC_GC_NACK);
      ahb(1'h1, OFS_CONTROL, 8'hc4);
      xf(1'h1, d1, 1'h0, 8'h1);
      i_tws_i2c_master.stop;
      $display("test 4 done");
      i_tws_i2c_master.start;
      xf(1'h1, v, 1'h0, 8'h0);
      rd("status", OFS_STATUS, SC_RX_ADDR);
      ahb(1'h1, OFS_CONTROL, 8'he4);
      i_tws_i2c_master.stop;
      rd("status", OFS_STATUS, SC_STOP_RESTART);
      ahb(1'h1, OFS_CONTROL, 8'he4);
      v = 8'h0;
      repeat (20) @(posedge clk) if (startIssue === 1'h1) v = 8'h1;
      note("start issue", 8'h1);
      got(v);
      ahb(1'h1, OFS_CONTROL, 8'h44);
      $display("test 5 done");
      arbLost <= 1'h1;
      i_tws_i2c_master.start;
      xf(1'h1, {seed[6:0] | 7'h01, 1'h1}, 1'h0, 8'h0);
      @(posedge clk) arbLost <= 1'h0;
      rd("status", OFS_STATUS, SC_TX_ARB);
      ahb(1'h1, OFS_DATA, d2);
      ahb(1'h1, OFS_CONTROL, 8'h84);
      xf(1'h0, 8'h0, 1'h1, d2);
      rd("status", OFS_STATUS, SC_TX_NACK);
      ahb(1'h1, OFS_CONTROL, 8'hc4);
      i_tws_i2c_master.stop;
      $display("test 6 done");
      test_done;
   end
endmodule : tws_slave_tb
`default_nettype wire
